/* File: design/ltm_buf_if.sv */
`timescale 1ns/10ps

// byte stream between register front end, queue and serialiser
interface ltm_buf_if;
   import ltm_pkg::*;
   ltm_byte_t wdata; // byte offered to the queue
   logic wvalid; // offer strobe
   logic wready; // queue has room
   ltm_byte_t rdata; // oldest byte in the queue
   logic rvalid; // queue holds a byte
   logic rready; // serialiser takes the byte

   modport queue (
      input wdata,
      input wvalid,
      output wready,
      output rdata,
      output rvalid,
      input rready
   );

   modport user (
      output wdata,
      output wvalid,
      input wready,
      input rdata,
      input rvalid,
      output rready
   );
endinterface

/* File: design/ltm_defs.svh */
`ifndef LTM_DEFS_SVH
`define LTM_DEFS_SVH

// register offsets
`define LTM_REG_CTRL 8'h08
`define LTM_REG_FIFO 8'h09
`define LTM_REG_STAT 8'h0A

// control register layout and reset value
`define LTM_CTRL_RST 8'h00
`define LTM_CTRL_SEL_LSB 0
`define LTM_CTRL_SEL_MSB 1
`define LTM_CTRL_PWM_BIT 2

// status register layout
`define LTM_STAT_EMPTY_BIT 0
`define LTM_STAT_FULL_BIT 1
`define LTM_STAT_BUSY_BIT 2

// bit framing: frame length in bits, bit timing in tone clock periods
`define LTM_FRAME_BITS 9
`define LTM_BIT_PERIODS 33
`define LTM_ONE_ON_PERIODS 11
`define LTM_ZERO_ON_PERIODS 22

// tone clock derivation from the system clock
`define LTM_SYS_CLK_HZ 250000000
`define LTM_TONE_HZ 22000
`define LTM_TONE_HALF_CYC (`LTM_SYS_CLK_HZ / (2 * `LTM_TONE_HZ))

// buffer geometry
`define LTM_BUF_DEPTH 2
`define LTM_BUF_WIDTH 8

`endif

/* File: design/ltm_fifo.sv */
`timescale 1ns/10ps
`include "ltm_defs.svh"

// two-entry byte queue; a stalled serialiser makes it fill up
module ltm_fifo
   import ltm_pkg::*;
(
   // clock and control
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   // stream
   ltm_buf_if.queue bus
);
   ltm_byte_t mem_q [`LTM_BUF_DEPTH]; // storage words
   ltm_byte_t mem_d [`LTM_BUF_DEPTH];
   logic wptr_q, wptr_d; // next slot to fill
   logic rptr_q, rptr_d; // oldest slot
   logic [1:0] cnt_q, cnt_d; // words held
   logic push; // accepted write
   logic pop; // accepted read

   // flags straight from the occupancy count
   assign bus.wready = (cnt_q != 2'(`LTM_BUF_DEPTH));
   assign bus.rvalid = (cnt_q != 2'h0);
   assign bus.rdata = mem_q[rptr_q];
   assign push = bus.wvalid && bus.wready && ce;
   assign pop = bus.rvalid && bus.rready && ce;

   // next pointers, count and storage
   always_comb begin
      mem_d = mem_q;
      wptr_d = wptr_q;
      rptr_d = rptr_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wptr_q] = bus.wdata;
         wptr_d = ~wptr_q;
      end
      if (pop) begin
         rptr_d = ~rptr_q;
      end
      // simultaneous push and pop leaves the count unchanged
      if (push && !pop) begin
         cnt_d = cnt_q + 2'h1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 2'h1;
      end
   end

   // registers only; reset empties the queue
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         mem_q <= '{default: 8'h00};
         wptr_q <= 1'b0;
         rptr_q <= 1'b0;
         cnt_q <= 2'h0;
      end else if (ce) begin
         mem_q <= mem_d;
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q <= cnt_d;
      end
   end
endmodule

/* File: design/ltm_pkg.sv */
package ltm_pkg;

   // transmitter states
   typedef enum logic {
      LTM_IDLE,
      LTM_SEND
   } ltm_state_t;

   // output selection, listed in the order of its two-bit encoding
   typedef enum logic [1:0] {
      LTM_SEL_LOW,
      LTM_SEL_HIGH,
      LTM_SEL_FIFO,
      LTM_SEL_TONE
   } ltm_sel_t;

   // one byte of the transmit queue
   typedef logic [7:0] ltm_byte_t;

endpackage

/* File: design/ltm_top.sv */
// Operation
// - host reads queue empty and full flags
// - reset leaves queue empty, idle transmitter
// - first byte written in queue mode starts transmission at the next rising tone edge
// - after last byte, idle with modulation off
// - MSB first, then odd parity bit
// - every bit lasts 33 tone clock periods
// - zero bit, PWM mode: 22 on, 11 off
// - zero bit, plain mode: on all 33
// - one bit: 11 on, 22 off
// - output is gated full-swing square wave
// - select: low, high, queue bursts, tone
// - queue mode releases pin after transmission
// - all-ones byte gives nine short bursts
// - zero byte, plain mode: 12.5 ms tone
// - host loads bytes by register writes
// - tone clock divided down from fast clock
`timescale 1ns/10ps
`include "ltm_defs.svh"

module ltm_top
   import ltm_pkg::*;
#(
   // system clock cycles per half tone period
   parameter int TONE_HALF = `LTM_TONE_HALF_CYC
)
(
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // tone pin and derived tone clock
   output logic tone_out,
   output logic tone_oe_n,
   output logic tone_clock
);
   // counter limits; fourteen divider bits cover half periods up to
   // 16384 system clock cycles, so the default tone fits with room
   // for a faster system clock
   localparam logic [13:0] HALF_M1 = 14'(TONE_HALF - 1);
   localparam logic [5:0] PER_LAST = 6'(`LTM_BIT_PERIODS - 1);
   localparam logic [5:0] ONE_ON = 6'(`LTM_ONE_ON_PERIODS);
   localparam logic [5:0] ZERO_ON = 6'(`LTM_ZERO_ON_PERIODS);
   localparam logic [3:0] BIT_LAST = 4'(`LTM_FRAME_BITS - 1);

   ltm_buf_if buf_if (); // queue between registers and serialiser

   // ---------------------------------------------------------------
   // tone clock divider
   // ---------------------------------------------------------------
   logic [13:0] div_q, div_d; // half period counter
   logic tone_q, tone_d; // free-running tone square wave
   logic tick; // rising edge of the tone clock

   // next divider values; period is two half counts
   // the host cannot retune the divider here: the tone rate is fixed
   // by the parameter, so a wrong system clock gives a wrong tone
   always_comb begin
      div_d = div_q + 14'h0001;
      tone_d = tone_q;
      tick = 1'b0;
      if (div_q == HALF_M1) begin
         div_d = 14'h0000;
         tone_d = ~tone_q;
         tick = ~tone_q;
      end
   end

   // divider registers
   // the divider freezes with ce like everything else, so a held
   // enable stretches the tone period
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         div_q <= 14'h0000;
         tone_q <= 1'b0;
      end else if (ce) begin
         div_q <= div_d;
         tone_q <= tone_d;
      end
   end

   // ---------------------------------------------------------------
   // register front end
   // ---------------------------------------------------------------
   logic [7:0] ctrl_q, ctrl_d; // control register
   logic [7:0] rdata_q, rdata_d; // registered read data
   ltm_sel_t sel; // decoded output selection
   logic pwm_mode; // zero bits use two-thirds on time
   logic busy; // transmitter is sending a frame
   logic [7:0] status; // assembled status byte

   assign sel = ltm_sel_t'(ctrl_q[`LTM_CTRL_SEL_MSB:`LTM_CTRL_SEL_LSB]);
   assign pwm_mode = ctrl_q[`LTM_CTRL_PWM_BIT];

   // byte writes go straight into the queue; a write while full is
   // dropped, so the host polls the full flag first
   assign buf_if.wdata = reg_wdata;
   assign buf_if.wvalid = reg_wr && (reg_addr == `LTM_REG_FIFO);

   // status byte built from live queue and transmitter state
   // busy stays high through the parity bit of the last frame, so the
   // host can tell a drained queue from a finished transmission
   always_comb begin
      status = 8'h00;
      status[`LTM_STAT_EMPTY_BIT] = ~buf_if.rvalid;
      status[`LTM_STAT_FULL_BIT] = ~buf_if.wready;
      status[`LTM_STAT_BUSY_BIT] = busy;
   end

   // next control and read data
   // a read and a write in one cycle return the old control value,
   // since the read data flop samples ctrl_q before it updates
   always_comb begin
      ctrl_d = ctrl_q;
      rdata_d = rdata_q;
      if (reg_wr && (reg_addr == `LTM_REG_CTRL)) begin
         ctrl_d = reg_wdata;
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `LTM_REG_CTRL: rdata_d = ctrl_q;
            `LTM_REG_STAT: rdata_d = status;
            // queue is write only; unmapped reads give zero
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // register front end flops
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_q <= `LTM_CTRL_RST;
         rdata_q <= 8'h00;
      end else if (ce) begin
         ctrl_q <= ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ---------------------------------------------------------------
   // transmit queue
   // ---------------------------------------------------------------
   // two entries let the host queue the next byte while one is on
   // the wire, so back-to-back frames need no tight polling
   ltm_fifo ltm_fifo_inst (
      .sys_clk (sys_clk),
      .rst_n (rst_n),
      .ce (ce),
      .bus (buf_if)
   );

   // ---------------------------------------------------------------
   // serialiser
   // ---------------------------------------------------------------
   ltm_state_t state_q, state_d; // transmitter state
   logic [8:0] shift_q, shift_d; // frame, current bit on top
   logic [3:0] bit_q, bit_d; // bit index within frame
   logic [5:0] per_q, per_d; // tone period within bit
   logic take; // pop the oldest queued byte
   logic [8:0] frame; // oldest byte with its parity

   // odd parity: the nine bits always carry an odd count of ones
   assign frame = {buf_if.rdata, ~^buf_if.rdata};
   assign buf_if.rready = take;
   assign busy = (state_q == LTM_SEND);

   // next serialiser state; stepping happens on rising tone edges, but leaving queue mode stops at once
   // starting only on a rising tone edge costs up to one tone period
   // of latency, but every bit then begins with a whole tone pulse
   always_comb begin
      state_d = state_q;
      shift_d = shift_q;
      bit_d = bit_q;
      per_d = per_q;
      take = 1'b0;
      unique case (state_q)
         LTM_IDLE: begin
            // a byte in the queue starts a frame, no go command
            if (sel == LTM_SEL_FIFO && buf_if.rvalid && tick) begin
               take = 1'b1;
               shift_d = frame;
               bit_d = 4'h0;
               per_d = 6'h00;
               state_d = LTM_SEND;
            end
         end
         LTM_SEND: begin
            if (sel != LTM_SEL_FIFO) begin
               // leaving queue mode abandons the frame in flight
               state_d = LTM_IDLE;
            end else if (tick) begin
               if (per_q == PER_LAST) begin
                  per_d = 6'h00;
                  if (bit_q == BIT_LAST) begin
                     if (buf_if.rvalid) begin
                        // parity runs straight into next byte
                        take = 1'b1;
                        shift_d = frame;
                        bit_d = 4'h0;
                     end else begin
                        state_d = LTM_IDLE;
                     end
                  end else begin
                     // MSB leaves first, parity last
                     shift_d = {shift_q[7:0], 1'b0};
                     bit_d = bit_q + 4'h1;
                  end
               end else begin
                  per_d = per_q + 6'h01;
               end
            end
         end
      endcase
   end

   // serialiser registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q <= LTM_IDLE;
         shift_q <= 9'h000;
         bit_q <= 4'h0;
         per_q <= 6'h00;
      end else if (ce) begin
         state_q <= state_d;
         shift_q <= shift_d;
         bit_q <= bit_d;
         per_q <= per_d;
      end
   end

   // ---------------------------------------------------------------
   // modulation gate and pin drive
   // ---------------------------------------------------------------
   logic gate; // tone allowed through in this period
   logic out_q, out_d; // pin level
   logic oe_n_q, oe_n_d; // pin enable, low drives
   logic tclk_q; // registered copy of the tone clock

   // PWM gate; an all-ones byte yields nine 0.5 ms bursts with 1 ms
   // gaps, a zero byte in plain mode one unbroken 12.5 ms tone
   always_comb begin
      gate = 1'b0;
      if (state_q == LTM_SEND) begin
         if (shift_q[8]) begin
            gate = (per_q < ONE_ON);
         end else if (pwm_mode) begin
            gate = (per_q < ZERO_ON);
         end else begin
            gate = 1'b1;
         end
      end
   end

   // pin selection; costs one cycle of latency for a clean flop output
   // the gate uses the same tone flop as the continuous tone mode, so
   // bursts and the plain tone share one phase
   always_comb begin
      out_d = 1'b0;
      oe_n_d = 1'b0;
      unique case (sel)
         LTM_SEL_LOW: out_d = 1'b0;
         LTM_SEL_HIGH: out_d = 1'b1;
         LTM_SEL_TONE: out_d = tone_q;
         LTM_SEL_FIFO: begin
            if (state_q == LTM_SEND) begin
               // full swing tone while gated, low between bursts
               out_d = gate & tone_q;
            end else begin
               // released while idle; modulation stays off
               oe_n_d = 1'b1;
            end
         end
      endcase
   end

   // pin registers; after reset the pin is driven low
   // driving low rather than releasing keeps the far side from seeing
   // a floating level while the host sets up the control register
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         out_q <= 1'b0;
         oe_n_q <= 1'b0;
         tclk_q <= 1'b0;
      end else if (ce) begin
         out_q <= out_d;
         oe_n_q <= oe_n_d;
         tclk_q <= tone_q;
      end
   end

   assign tone_out = out_q;
   assign tone_oe_n = oe_n_q;
   assign tone_clock = tclk_q;
endmodule

/* File: tb/lnb_tone_burst_modulator_test.sv */
`timescale 1ns/10ps
`include "ltm_defs.svh"
module lnb_tone_burst_modulator_test;
   import ltm_pkg::*;
   // tone divider as passed to TONE_HALF; a short half period keeps runs brief
   localparam int TH = 2;
   localparam int BITC = `LTM_BIT_PERIODS * 2 * TH; // cycles per bit
   localparam int ON1 = `LTM_ONE_ON_PERIODS;
   localparam int ON0 = `LTM_ZERO_ON_PERIODS;
   // design inputs
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1; // dropped once to check that state freezes
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   // design outputs
   logic [7:0] reg_rdata;
   logic tone_out;
   logic tone_oe_n;
   logic tone_clock;
   // receiver side
   logic clr = 1'b1;
   logic [31:0] rx_bits;
   logic [7:0] rx_n;
   logic [15:0] rises;
   // bookkeeping
   int n_errors = 0;
   int checks = 0;
   logic [7:0] rv; // last register read
   logic lo;
   logic hi;
   // rows: control value, lowest and highest pin level
   logic [9:0] rows [3] = '{{8'h00, 2'b00}, {8'hF1, 2'b11}, {8'h0B, 2'b01}};

   always #2 sys_clk = ~sys_clk;

   ltm_top #(.TONE_HALF(TH)) ltm_top_inst (.sys_clk, .rst_n, .ce,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tone_out,
      .tone_oe_n, .tone_clock);
   ltm_lnb_model #(.BITC(BITC)) ltm_lnb_model_inst (.sys_clk, .clr,
      .tone_out, .tone_oe_n, .rx_bits, .rx_n, .rises);

   task automatic chk(input logic [31:0] s, input logic [31:0] e,
      input string what);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, e, s);
      end
   endtask
   // one-cycle strobes, released an edge before the next access
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      rv = reg_rdata;
   endtask
   // lowest and highest pin level over four tone periods
   task automatic span();
      lo = 1'b1;
      hi = 1'b0;
      repeat (16) begin
         @(posedge sys_clk);
         lo = lo & tone_out;
         hi = hi | tone_out;
      end
   endtask
   task automatic put(input logic [7:0] b);
      int i;
      for (i = 0; i < 100; i++) begin
         rd(`LTM_REG_STAT);
         if (rv[1] === 1'b0) break;
      end
      wr(`LTM_REG_FIFO, b);
   endtask
   // poll until empty and not busy; pin follows a cycle later
   task automatic wait_idle();
      int i;
      for (i = 0; i < 2000; i++) begin
         rd(`LTM_REG_STAT);
         if (rv[2:0] === 3'b001) break;
      end
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic start_rx();
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
   endtask
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rd(`LTM_REG_STAT);
      chk(rv, 8'h01, "status");
      rd(`LTM_REG_CTRL);
      chk(rv, `LTM_CTRL_RST, "control");
      rd(`LTM_REG_FIFO);
      chk(rv, 8'h00, "queue read");
      rd(8'h5E);
      chk(rv, 8'h00, "unmapped read");
      wr(`LTM_REG_STAT, 8'hFF);
      rd(`LTM_REG_STAT);
      chk(rv, 8'h01, "status after write");
      $display("test reset: done");
      foreach (rows[k]) begin
         wr(`LTM_REG_CTRL, rows[k][9:2]);
         rd(`LTM_REG_CTRL);
         chk(rv, rows[k][9:2], "control readback");
         span();
         chk({lo, hi}, rows[k][1:0], "pin span");
      end
      $display("test selections: done");
      // fill under constant low so nothing drains yet
      wr(`LTM_REG_CTRL, 8'h04);
      wr(`LTM_REG_FIFO, 8'hA5);
      rd(`LTM_REG_STAT);
      chk(rv[1:0], 2'b00, "flags one byte");
      wr(`LTM_REG_FIFO, 8'h3D);
      rd(`LTM_REG_STAT);
      chk(rv[1:0], 2'b10, "flags full");
      wr(`LTM_REG_FIFO, 8'h77); // refused while full
      start_rx();
      wr(`LTM_REG_CTRL, 8'h06);
      wait_idle();
      chk(rx_n, 18, "bits");
      chk(rx_bits[17:0], {8'hA5, 1'b1, 8'h3D, 1'b0}, "frames");
      chk(rises, 10 * ON1 + 8 * ON0, "tone periods");
      chk(tone_oe_n, 1'b1, "pin released");
      span();
      chk({lo, hi}, 2'b00, "idle pin");
      $display("test queue: done");
      start_rx();
      put(8'hFF);
      repeat (2 * TH + 2) @(posedge sys_clk);
      chk(tone_oe_n, 1'b0, "start");
      wait_idle();
      chk(rx_bits[8:0], 9'h1FF, "burst bits");
      chk(rises, 9 * ON1, "burst periods");
      wr(`LTM_REG_CTRL, 8'h02);
      start_rx();
      put(8'h00);
      wait_idle();
      chk(rx_bits[8:0], 9'h001, "plain bits");
      chk(rises, 8 * `LTM_BIT_PERIODS + ON1, "plain periods");
      $display("test bursts: done");
      // reset in mid frame: queue flushed, pin driven low again
      wr(`LTM_REG_CTRL, 8'h06);
      put(8'h5A);
      repeat (40) @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      chk({tone_out, tone_oe_n}, 2'b00, "pin after reset");
      rd(`LTM_REG_STAT);
      chk(rv, 8'h01, "status after reset");
      $display("test mid reset: done");
      // frozen enable: ten held edges would invert a running tone
      wr(`LTM_REG_CTRL, 8'h03);
      ce <= 1'b0;
      @(posedge sys_clk);
      lo = tone_clock;
      hi = tone_out;
      repeat (10) @(posedge sys_clk);
      chk({tone_clock, tone_out}, {lo, hi}, "frozen pins");
      ce <= 1'b1;
      $display("test enable: done");
      give_verdict();
   end

   // the sequence needs well under 8000 cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      give_verdict();
   end
endmodule

/* File: tb/ltm_lnb_model.sv */
`timescale 1ns/10ps
// far-side receiver: turns pulse-width bits back into data
module ltm_lnb_model #(
   parameter int BITC = 132 // sys_clk cycles per bit
)
(
   // clock and clear
   input wire logic sys_clk,
   input wire logic clr,
   // tone pin
   input wire logic tone_out,
   input wire logic tone_oe_n,
   // decoded traffic
   output logic [31:0] rx_bits,
   output logic [7:0] rx_n,
   output logic [15:0] rises
);
   logic prev = 1'b0; // pin level one cycle ago
   int cnt = 0; // cycles into the current bit
   int won = 0; // tone periods in the current bit
   // a third of a bit reads as one, longer bursts as zero
   always @(posedge sys_clk) begin
      if (clr) begin
         rx_bits <= 32'h0;
         rx_n <= 8'h00;
         rises <= 16'h0000;
         cnt = 0;
         won = 0;
      end else if (!tone_oe_n) begin
         if (tone_out && !prev) begin
            rises <= rises + 16'h0001;
            won = won + 1;
         end
         cnt = cnt + 1;
         if (cnt == BITC) begin
            rx_bits <= {rx_bits[30:0], won < 17};
            rx_n <= rx_n + 8'h01;
            cnt = 0;
            won = 0;
         end
      end else begin
         // a release may cut the last window by a cycle
         if (cnt > BITC / 2) begin
            rx_bits <= {rx_bits[30:0], won < 17};
            rx_n <= rx_n + 8'h01;
         end
         cnt = 0;
         won = 0;
      end
      prev <= tone_out;
   end
endmodule

/* File: tb/ltm_top_chk.sv */
`timescale 1ns/10ps
// watches register port and tone pin of the modulator top
module ltm_top_chk #(
   parameter int TONE_HALF = 2 // cycles per half tone period
)
(
   // clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic ce,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // tone pin and tone clock
   input wire logic tone_out,
   input wire logic tone_oe_n,
   input wire logic tone_clock
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   int hold_q; // cycles the tone clock kept its level
   int hold_d;
   logic tck_q; // tone clock one cycle ago
   // a frozen divider (ce low) must not count as a long half period
   always_comb begin
      hold_d = hold_q;
      if (ce) begin
         hold_d = (tone_clock != tck_q) ? 0 : hold_q + 1;
      end
   end
   // starts at -2: the tone flop and its registered copy trail reset
   always_ff @(posedge sys_clk) begin
      hold_q <= rst_n ? hold_d : -2;
      if (ce) begin
         tck_q <= tone_clock;
      end
   end
   a_reset_quiet: assert property (disable iff (1'b0)
      !rst_n && ce |=> reg_rdata == 8'h00 && !tone_clock && !tone_out
      && !tone_oe_n) else $error("outputs not cleared by reset");
   a_tone_half: assert property (hold_q < TONE_HALF)
      else $error("tone clock half period too long");
   a_idle_quiet: assert property (tone_oe_n |-> !tone_out)
      else $error("pin released but driven high");
   a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   a_ctrl_readback: assert property (ce && reg_wr && reg_addr == 8'h08
      ##1 !reg_wr ##1 ce && reg_rd && !reg_wr && reg_addr == 8'h08
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("control lost");
   a_queue_rd_zero: assert property (ce && reg_rd && reg_addr == 8'h09
      |=> reg_rdata == 8'h00) else $error("queue register readable");
   a_status_shape: assert property (ce && reg_rd && reg_addr == 8'h0A
      |=> reg_rdata[7:3] == 5'h00 && !(reg_rdata[0] && reg_rdata[1]))
      else $error("status flags inconsistent");
   a_low_mode: assert property (ce && reg_wr && reg_addr == 8'h08
      && reg_wdata[1:0] == 2'b00 ##1 ce && !reg_wr
      |=> !tone_out && !tone_oe_n) else $error("low selection wrong");
   a_high_mode: assert property (ce && reg_wr && reg_addr == 8'h08
      && reg_wdata[1:0] == 2'b01 ##1 ce && !reg_wr
      |=> tone_out && !tone_oe_n) else $error("high selection wrong");
endmodule

bind ltm_top ltm_top_chk #(.TONE_HALF(TONE_HALF)) ltm_top_chk_inst (
   .sys_clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .tone_out, .tone_oe_n, .tone_clock);
